// >>> gpio_pkg.sv
// Package of offsets, reset values and types for the shared I/O port.
package gpio_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets.
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_DIR = 8'h00;
	localparam logic [7:0] OFF_LATCH = 8'h04;
	localparam logic [7:0] OFF_LEVEL = 8'h08;
	localparam logic [7:0] OFF_ODC = 8'h0C;
	localparam logic [7:0] OFF_ANALOG = 8'h10;
	localparam logic [7:0] OFF_CNEN_LO = 8'h14;
	localparam logic [7:0] OFF_CNEN_HI = 8'h18;
	localparam logic [7:0] OFF_PU_LO = 8'h1C;
	localparam logic [7:0] OFF_PU_HI = 8'h20;
	localparam logic [7:0] OFF_PD_LO = 8'h24;
	localparam logic [7:0] OFF_PD_HI = 8'h28;
	localparam logic [7:0] OFF_STATUS = 8'h2C;
	// ----------------------------------------------------------------
	// Field positions, sizes and reset values.
	// ----------------------------------------------------------------
	localparam int STAT_CHANGE_BIT = 0;
	localparam int STAT_RESTORE_BIT = 1;
	localparam int CN_LOW_BITS = 16;
	localparam int PORT_WIDTH_DEF = 16;
	localparam int CN_COUNT_DEF = 23;
	localparam logic [31:0] DIR_RESET = 32'hFFFFFFFF;
	localparam logic [31:0] ZERO_RESET = 32'h00000000;
	// ----------------------------------------------------------------
	// Bus slave states.
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_WRITE = 3'b010,
		BUS_READ = 3'b100
	} bus_state_t;
endpackage : gpio_pkg

// >>> cn_if.sv
// Interface between the port and its change detector.
`timescale 1ns/100ps
interface cn_if #(parameter int N = 23);
	logic [N-1:0] level;
	logic [N-1:0] enable;
	logic change;
	modport owner(output level, output enable, input change);
	modport detector(input level, input enable, output change);
endinterface : cn_if

// >>> change_detect.sv
// Change-of-state detector for the change-notification inputs.
`timescale 1ns/100ps
module change_detect #(
	parameter int N = 23
) (
	input wire logic core_clk_in, // System clock.
	input wire logic reset_in, // Synchronous reset, active high.
	cn_if.detector cn // Levels, enables and change pulse.
);
	logic [N-1:0] prev_ff;
	logic [N-1:0] nxt_prev;
	logic change_ff;
	logic nxt_change;

	// Compare each enabled input with its previous sample.
	always_comb begin
		nxt_prev = cn.level;
		nxt_change = |((cn.level ^ prev_ff) & cn.enable); // [RL22] [RL17]
	end

	// Register the samples and the one-cycle change pulse.
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			prev_ff <= '0;
			change_ff <= 1'b0;
		end else begin
			prev_ff <= nxt_prev;
			change_ff <= nxt_change;
		end
	end

	assign cn.change = change_ff;

	// The expectation is rebuilt from two old level samples, not from
	// prev_ff, so a stale or skipped previous sample is caught as well.
	a_change_cause: assert property (@(posedge core_clk_in) // [RL22]
		disable iff (reset_in)
		cn.change |-> |(($past(cn.level) ^ $past(cn.level, 2))
		& $past(cn.enable)))
		else $error("change pulse without enabled edge");
endmodule : change_detect

// >>> shared_io_port.sv
// Shared parallel I/O port with change notification, AHB-Lite slave.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
// Summary of operation
// RL1: Active enabled peripheral drives pin; port driver off, pin still readable.
// RL2: Enabled but idle peripheral leaves the pin to the port.
// RL3: Muxes pick data and enable owner; port output never loops to peripheral.
// RL4: Direction bit 1 means input, 0 means output.
// RL5: Reset sets every direction bit, making all pins inputs.
// RL6: Latch register reads the latch and writes the latch.
// RL7: Level register reads sampled pins; writes go to the latch.
// RL8: Unimplemented bits read zero in latch, direction and level.
// RL9: Pins shared only with input functions behave as plain port pins.
// RL10: Pins hold state through deep sleep until software clears restore.
// RL11: Per-pin open-drain bit makes that pin open-drain; the code ignores it while a busy peripheral owns the pin.
// RL12: Software keeps analog pins as inputs.
// RL13: Level reads return zero on analog-configured pins.
// RL14: Software waits one cycle between port write and read.
// RL15: Enabled input change raises an interrupt request.
// RL16: Up to 23 change inputs, numbered 0 to 22.
// RL17: Two enable registers select which change inputs interrupt.
// RL18: Two registers enable weak pull-ups per change input.
// RL19: Two registers enable weak pull-downs per change input.
// RL20: Software never enables pull-up and pull-down together.
// RL21: Software disables pulls on pins used as digital outputs.
// RL22: Change is a compare with last sample; one shared flag, software clears.
module shared_io_port #(
	parameter int WIDTH = gpio_pkg::PORT_WIDTH_DEF,
	parameter int CN_COUNT = gpio_pkg::CN_COUNT_DEF,
	parameter logic [31:0] IMPL_MASK = 32'h0000FFFF
) (
	input wire logic core_clk_in, // System clock.
	input wire logic reset_in, // Synchronous reset, active high.
	input wire logic hsel_in, // AHB slave select.
	input wire logic [31:0] haddr_in, // AHB address.
	input wire logic [1:0] htrans_in, // AHB transfer type.
	input wire logic hwrite_in, // AHB write.
	input wire logic [2:0] hsize_in, // AHB size, word only.
	input wire logic [31:0] hwdata_in, // AHB write data.
	input wire logic hready_in, // AHB bus ready.
	output logic [31:0] hrdata_out, // AHB read data.
	output logic hreadyout_out, // AHB slave ready.
	output logic hresp_out, // AHB response, always OKAY.
	input wire logic [WIDTH-1:0] pin_in, // Pad input levels.
	output logic [WIDTH-1:0] pin_out, // Pad output data.
	output logic [WIDTH-1:0] pin_oe_out, // Pad drive enable.
	input wire logic [WIDTH-1:0] periph_en_in, // Peripheral enabled.
	input wire logic [WIDTH-1:0] periph_oe_in, // Peripheral drives.
	input wire logic [WIDTH-1:0] periph_data_in, // Peripheral data.
	output logic [WIDTH-1:0] periph_din_out, // Pin level to peripheral.
	input wire logic [CN_COUNT-1:0] cn_in, // Change inputs.
	output logic [CN_COUNT-1:0] pullup_out, // Weak pull-up enables.
	output logic [CN_COUNT-1:0] pulldown_out, // Weak pull-downs.
	input wire logic deep_sleep_in, // Deep sleep active.
	output logic restore_out, // Pad hold active.
	output logic change_irq_out // Change interrupt request.
);
	localparam int CN_HI = CN_COUNT - gpio_pkg::CN_LOW_BITS;
	localparam logic [WIDTH-1:0] MASK = IMPL_MASK[WIDTH-1:0];

	// ----------------------------------------------------------------
	// Parameter checks.
	// ----------------------------------------------------------------
	if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
		$error("WIDTH must be 1 to 32");
	end
	if (CN_COUNT <= gpio_pkg::CN_LOW_BITS || CN_COUNT > 32) begin : g_bad_cn
		$error("CN_COUNT must be 17 to 32");
	end

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	gpio_pkg::bus_state_t bus_ff, nxt_bus;
	logic [7:0] addr_ff, nxt_addr;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic hready_ff, nxt_hready;
	logic [WIDTH-1:0] dir_ff, nxt_dir;
	logic [WIDTH-1:0] lat_ff, nxt_lat;
	logic [WIDTH-1:0] odc_ff, nxt_odc;
	logic [WIDTH-1:0] ana_ff, nxt_ana;
	logic [WIDTH-1:0] smp_ff, nxt_smp;
	logic [CN_COUNT-1:0] cnen_ff, nxt_cnen;
	logic [CN_COUNT-1:0] pu_ff, nxt_pu;
	logic [CN_COUNT-1:0] pd_ff, nxt_pd;
	logic [CN_COUNT-1:0] cnsmp_ff, nxt_cnsmp;
	logic flag_ff, nxt_flag;
	logic restore_ff, nxt_restore;
	logic [WIDTH-1:0] pad_ff, nxt_pad;
	logic [WIDTH-1:0] oe_ff, nxt_oe;
	logic [WIDTH-1:0] pdin_ff, nxt_pdin;
	logic [WIDTH-1:0] drv_data, drv_oe, port_drive;
	logic wr_now;
	logic [31:0] rd_val;

	cn_if #(.N(CN_COUNT)) cn ();

	change_detect #(.N(CN_COUNT)) u_detect (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.cn(cn.detector)
	);

	assign cn.level = cnsmp_ff;
	assign cn.enable = cnen_ff;

	// Map an address onto a register slot; 0 means no register.
	function automatic logic [3:0] reg_slot(input logic [7:0] a);
		case (a)
			gpio_pkg::OFF_DIR: reg_slot = 4'h1;
			gpio_pkg::OFF_LATCH: reg_slot = 4'h2;
			gpio_pkg::OFF_LEVEL: reg_slot = 4'h3;
			gpio_pkg::OFF_ODC: reg_slot = 4'h4;
			gpio_pkg::OFF_ANALOG: reg_slot = 4'h5;
			gpio_pkg::OFF_CNEN_LO: reg_slot = 4'h6;
			gpio_pkg::OFF_CNEN_HI: reg_slot = 4'h7;
			gpio_pkg::OFF_PU_LO: reg_slot = 4'h8;
			gpio_pkg::OFF_PU_HI: reg_slot = 4'h9;
			gpio_pkg::OFF_PD_LO: reg_slot = 4'hA;
			gpio_pkg::OFF_PD_HI: reg_slot = 4'hB;
			gpio_pkg::OFF_STATUS: reg_slot = 4'hC;
			default: reg_slot = 4'h0;
		endcase
	endfunction : reg_slot

	// ----------------------------------------------------------------
	// Output multiplexers, one slice per pin.
	// ----------------------------------------------------------------
	// A busy peripheral wins the pin; an idle one hands it back.
	// Open drain only ever pulls low, so its data is always zero.
	for (genvar i = 0; i < WIDTH; i++) begin : g_pin
		logic own;
		assign own = periph_en_in[i] & periph_oe_in[i]; // [RL1] [RL2]
		// A pin whose peripheral never drives stays a plain port pin.
		assign port_drive[i] = MASK[i] & ~own & ~dir_ff[i]; // [RL4] [RL9]
		assign drv_data[i] = own ? periph_data_in[i] :
			(odc_ff[i] ? 1'b0 : lat_ff[i]); // [RL3] [RL11]
		assign drv_oe[i] = own | (port_drive[i] &
			(~odc_ff[i] | ~lat_ff[i])); // [RL3] [RL11]
	end

	// ----------------------------------------------------------------
	// Read data mux.
	// ----------------------------------------------------------------
	// Analog pins read as zero in the level register; unimplemented bits read as zero.
	always_comb begin
		rd_val = '0;
		case (reg_slot(addr_ff))
			4'h1: rd_val[WIDTH-1:0] = dir_ff & MASK; // [RL8]
			4'h2: rd_val[WIDTH-1:0] = lat_ff & MASK; // [RL6]
			4'h3: rd_val[WIDTH-1:0] = smp_ff & ~ana_ff & MASK; // [RL7] [RL13]
			4'h4: rd_val[WIDTH-1:0] = odc_ff;
			4'h5: rd_val[WIDTH-1:0] = ana_ff;
			4'h6: rd_val[15:0] = cnen_ff[15:0];
			4'h7: rd_val[CN_HI-1:0] = cnen_ff[CN_COUNT-1:16];
			4'h8: rd_val[15:0] = pu_ff[15:0];
			4'h9: rd_val[CN_HI-1:0] = pu_ff[CN_COUNT-1:16];
			4'hA: rd_val[15:0] = pd_ff[15:0];
			4'hB: rd_val[CN_HI-1:0] = pd_ff[CN_COUNT-1:16];
			4'hC: begin
				rd_val[gpio_pkg::STAT_CHANGE_BIT] = flag_ff;
				rd_val[gpio_pkg::STAT_RESTORE_BIT] = restore_ff;
			end
			default: rd_val = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus slave: writes take no wait state, reads one.
	// ----------------------------------------------------------------
	// The read wait lets a write just before it land first.
	always_comb begin
		nxt_bus = gpio_pkg::BUS_IDLE;
		nxt_addr = addr_ff;
		nxt_hready = 1'b1;
		nxt_hrdata = hrdata_ff;
		if (bus_ff == gpio_pkg::BUS_READ) begin
			nxt_hrdata = rd_val;
		end
		if (hsel_in && htrans_in[1] && hready_in) begin
			nxt_addr = haddr_in[7:0];
			case (hwrite_in)
				1'b1: nxt_bus = gpio_pkg::BUS_WRITE;
				1'b0: begin
					nxt_bus = gpio_pkg::BUS_READ;
					nxt_hready = 1'b0;
				end
				default: nxt_bus = gpio_pkg::BUS_IDLE;
			endcase
		end
	end

	assign wr_now = (bus_ff == gpio_pkg::BUS_WRITE);

	// ----------------------------------------------------------------
	// Register writes and flags.
	// ----------------------------------------------------------------
	// Set beats clear on the change flag and the restore bit.
	always_comb begin
		nxt_dir = dir_ff;
		nxt_lat = lat_ff;
		nxt_odc = odc_ff;
		nxt_ana = ana_ff;
		nxt_cnen = cnen_ff;
		nxt_pu = pu_ff;
		nxt_pd = pd_ff;
		nxt_flag = flag_ff;
		nxt_restore = restore_ff;
		if (wr_now) begin
			case (reg_slot(addr_ff))
				4'h1: nxt_dir = hwdata_in[WIDTH-1:0] & MASK; // [RL4] [RL8]
				4'h2: nxt_lat = hwdata_in[WIDTH-1:0] & MASK; // [RL6]
				4'h3: nxt_lat = hwdata_in[WIDTH-1:0] & MASK; // [RL7]
				4'h4: nxt_odc = hwdata_in[WIDTH-1:0] & MASK; // [RL11]
				4'h5: nxt_ana = hwdata_in[WIDTH-1:0] & MASK;
				4'h6: nxt_cnen[15:0] = hwdata_in[15:0]; // [RL17]
				4'h7: nxt_cnen[CN_COUNT-1:16] = hwdata_in[CN_HI-1:0];
				4'h8: nxt_pu[15:0] = hwdata_in[15:0]; // [RL18]
				4'h9: nxt_pu[CN_COUNT-1:16] = hwdata_in[CN_HI-1:0];
				4'hA: nxt_pd[15:0] = hwdata_in[15:0]; // [RL19]
				4'hB: nxt_pd[CN_COUNT-1:16] = hwdata_in[CN_HI-1:0];
				4'hC: begin
					if (hwdata_in[gpio_pkg::STAT_CHANGE_BIT]) begin
						nxt_flag = 1'b0; // [RL22]
					end
					if (!hwdata_in[gpio_pkg::STAT_RESTORE_BIT]) begin
						nxt_restore = 1'b0; // [RL10]
					end
				end
				default: nxt_flag = flag_ff;
			endcase
		end
		if (cn.change) begin
			nxt_flag = 1'b1; // [RL15] [RL22]
		end
		if (deep_sleep_in) begin
			nxt_restore = 1'b1; // [RL10]
		end
	end

	// ----------------------------------------------------------------
	// Pad and sample path.
	// ----------------------------------------------------------------
	// While restore is set the pads keep their last drive.
	always_comb begin
		nxt_smp = pin_in;
		nxt_cnsmp = cn_in; // [RL16]
		nxt_pad = restore_ff ? pad_ff : drv_data; // [RL10]
		nxt_oe = restore_ff ? oe_ff : (drv_oe & MASK); // [RL10] [RL8]
		nxt_pdin = pin_in & ~port_drive; // [RL3]
	end

	// Register every group of state.
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			bus_ff <= gpio_pkg::BUS_IDLE;
			addr_ff <= 8'h00;
			hrdata_ff <= gpio_pkg::ZERO_RESET;
			hready_ff <= 1'b1;
			dir_ff <= gpio_pkg::DIR_RESET[WIDTH-1:0] & MASK; // [RL5]
			lat_ff <= '0;
			odc_ff <= '0;
			ana_ff <= '0;
			smp_ff <= '0;
			cnen_ff <= '0;
			pu_ff <= '0;
			pd_ff <= '0;
			cnsmp_ff <= '0;
			flag_ff <= 1'b0;
			restore_ff <= 1'b0;
			pad_ff <= '0;
			oe_ff <= '0;
			pdin_ff <= '0;
		end else begin
			bus_ff <= nxt_bus;
			addr_ff <= nxt_addr;
			hrdata_ff <= nxt_hrdata;
			hready_ff <= nxt_hready;
			dir_ff <= nxt_dir;
			lat_ff <= nxt_lat;
			odc_ff <= nxt_odc;
			ana_ff <= nxt_ana;
			smp_ff <= nxt_smp;
			cnen_ff <= nxt_cnen;
			pu_ff <= nxt_pu;
			pd_ff <= nxt_pd;
			cnsmp_ff <= nxt_cnsmp;
			flag_ff <= nxt_flag;
			restore_ff <= nxt_restore;
			pad_ff <= nxt_pad;
			oe_ff <= nxt_oe;
			pdin_ff <= nxt_pdin;
		end
	end

	// Outputs come straight from flip-flops, except hresp_out, which is tied to OKAY.
	assign hrdata_out = hrdata_ff;
	assign hreadyout_out = hready_ff;
	assign hresp_out = 1'b0;
	assign pin_out = pad_ff;
	assign pin_oe_out = oe_ff;
	assign periph_din_out = pdin_ff;
	assign pullup_out = pu_ff; // [RL18]
	assign pulldown_out = pd_ff; // [RL19]
	assign restore_out = restore_ff;
	assign change_irq_out = flag_ff; // [RL15]

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	a_periph_owns_pin: assert property ( // [RL1]
		!restore_ff |=> ((pin_oe_out & $past(periph_en_in & periph_oe_in
		& MASK)) == $past(periph_en_in & periph_oe_in & MASK)))
		else $error("busy peripheral lost its pin");
	a_port_drives_out: assert property ( // [RL2]
		!restore_ff |=> ((pin_oe_out & $past(port_drive & ~odc_ff))
		== $past(port_drive & ~odc_ff)))
		else $error("port output not driven");
	a_input_no_drive: assert property ( // [RL4]
		!restore_ff |=> ((pin_oe_out & $past(dir_ff & ~(periph_en_in
		& periph_oe_in))) == '0))
		else $error("input pin driven");
	a_no_loop_back: assert property ( // [RL3]
		1'b1 |=> ((periph_din_out & $past(port_drive)) == '0))
		else $error("port output looped to peripheral");
	a_reset_inputs: assert property ( // [RL5]
		$fell(reset_in) |-> (dir_ff == MASK))
		else $error("pins not inputs after reset");
	a_level_to_latch: assert property ( // [RL7]
		(wr_now && reg_slot(addr_ff) == 4'h3) |=>
		(lat_ff == ($past(hwdata_in[WIDTH-1:0]) & MASK)))
		else $error("level write missed latch");
	a_unimpl_zero: assert property ( // [RL8]
		((dir_ff | lat_ff | pin_oe_out) & ~MASK) == '0)
		else $error("unimplemented bit active");
	a_hold_pads: assert property ( // [RL10]
		(restore_ff && $past(restore_ff)) |->
		($stable(pin_out) && $stable(pin_oe_out)))
		else $error("pads moved during hold");
	a_open_drain_low: assert property ( // [RL11]
		!restore_ff |=> ((pin_out & $past(odc_ff & ~(periph_en_in
		& periph_oe_in))) == '0))
		else $error("open drain drove high");
	a_analog_reads_zero: assert property ( // [RL13]
		(bus_ff == gpio_pkg::BUS_READ && reg_slot(addr_ff) == 4'h3)
		|=> ((hrdata_out[WIDTH-1:0] & $past(ana_ff)) == '0) && hreadyout_out)
		else $error("analog pin read non-zero");
	a_change_sets_flag: assert property ( // [RL15]
		cn.change |=> change_irq_out)
		else $error("change did not raise request");

	c_change_irq: cover property (cn.change ##1 change_irq_out);
	c_periph_takeover: cover property ($rose(|(periph_en_in & periph_oe_in)));
	c_hold_release: cover property ($fell(restore_ff));
	c_read_level: cover property (bus_ff == gpio_pkg::BUS_READ
		&& reg_slot(addr_ff) == 4'h3);
endmodule : shared_io_port

// >>> pad_model.sv
// Pad model: resolves each port pin from the port drive and outside sources.
`timescale 1ns/100ps
module pad_model (
	input wire logic clk_in, // System clock.
	input wire logic [15:0] drive_in, // Port pad data.
	input wire logic [15:0] oe_in, // Port pad drive enable.
	input wire logic [15:0] ext_val_in, // Outside driver data.
	input wire logic [15:0] ext_en_in, // Outside driver enable.
	output logic [15:0] level_out // Resolved pad level.
);
	logic [15:0] float_ff;
	// ----------------------------------------------------------------
	// Pad resolution.
	// ----------------------------------------------------------------
	// A floating pad flips every cycle, so a stale level is never trusted.
	initial begin
		float_ff = 16'h5A5A;
	end
	// The floating pattern advances on each rising edge.
	always @(posedge clk_in) begin
		float_ff <= ~float_ff;
	end
	// The port wins where it drives, which stands in for a stiff driver.
	always_comb begin
		level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_val_in)
			| (~oe_in & ~ext_en_in & float_ff);
	end
endmodule : pad_model

// >>> shared_io_port_with_change_notice_tb.sv
// Self-checking testbench for the shared I/O port.
`timescale 1ns/100ps
module shared_io_port_with_change_notice_tb;
	localparam int LIMIT = 6000;
	localparam logic [31:0] MASK = 32'h0000FFFF;
	logic clk, rst, hsel, hwrite, dsleep, hready, hresp, restore, irq;
	logic [31:0] haddr, hwdata, hrdata, seed;
	logic [1:0] htrans;
	logic [15:0] pin_lvl, pin_o, pin_oe, p_en, p_oe, p_dat, p_din;
	logic [15:0] ext_v, ext_e, ana;
	logic [22:0] cn, pu, pd;
	int n_errors, num_checks, cycles;
	// ----------------------------------------------------------------
	// Design, pads and clock.
	// ----------------------------------------------------------------
	shared_io_port #(.WIDTH(16), .CN_COUNT(23), .IMPL_MASK(MASK))
		shared_io_port_inst (.core_clk_in(clk), .reset_in(rst),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .pin_in(pin_lvl), .pin_out(pin_o),
		.pin_oe_out(pin_oe), .periph_en_in(p_en), .periph_oe_in(p_oe),
		.periph_data_in(p_dat), .periph_din_out(p_din), .cn_in(cn),
		.pullup_out(pu), .pulldown_out(pd), .deep_sleep_in(dsleep),
		.restore_out(restore), .change_irq_out(irq));
	pad_model pad_model_inst (.clk_in(clk), .drive_in(pin_o),
		.oe_in(pin_oe), .ext_val_in(ext_v), .ext_en_in(ext_e),
		.level_out(pin_lvl));
	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// A hung handshake ends the run here as a failure.
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_errors++;
			summarize();
		end
	end
	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	// Waits for the next edge at which the bus is ready.
	task automatic bus_wait();
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
	endtask : bus_wait
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= 1'b1;
		bus_wait();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		bus_wait();
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= 1'b0;
		bus_wait();
		hsel <= 1'b0;
		htrans <= 2'b00;
		bus_wait();
		check(hrdata, e);
	endtask : rchk
	// Pads follow the registers one edge after the write lands.
	task automatic settle();
		repeat (3) @(posedge clk);
	endtask : settle
	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		{hsel, hwrite, dsleep, htrans} = 5'h00;
		{haddr, hwdata} = 64'h0;
		{p_en, p_oe, p_dat, ext_v} = 64'h0;
		ext_e = 16'hFFFF;
		cn = 23'h0;
		seed = 32'hAF82;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(gpio_pkg::OFF_DIR, MASK);
		check({16'h0, pin_oe}, 32'h0);
		// Random latch, direction and analog mixes; analog pins stay inputs.
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			ana = ~seed[15:0] & seed[27:12];
			ext_v <= seed[31:16];
			wr(gpio_pkg::OFF_LATCH, seed);
			rchk(gpio_pkg::OFF_LATCH, seed & MASK);
			wr(gpio_pkg::OFF_DIR, ~seed);
			wr(gpio_pkg::OFF_ANALOG, {16'h0, ana});
			settle();
			check({16'h0, pin_oe}, {16'h0, seed[15:0]});
			check({16'h0, pin_o & seed[15:0]}, {16'h0, seed[15:0]});
			rchk(gpio_pkg::OFF_LEVEL, {16'h0, (seed[15:0]
				| (~seed[15:0] & seed[31:16])) & ~ana});
			wr(gpio_pkg::OFF_LEVEL, ~seed);
			rchk(gpio_pkg::OFF_LATCH, ~seed & MASK);
		end
		// Open-drain on the low byte drives only zeros.
		wr(gpio_pkg::OFF_ANALOG, 32'h0);
		wr(gpio_pkg::OFF_DIR, 32'h0);
		wr(gpio_pkg::OFF_LATCH, 32'h0F0F);
		wr(gpio_pkg::OFF_ODC, 32'h00FF);
		settle();
		check({pin_oe, pin_o}, {16'hFFF0, 16'h0F00});
		// Busy peripheral bits, idle enabled bits and port bits.
		wr(gpio_pkg::OFF_ODC, 32'h0);
		wr(gpio_pkg::OFF_LATCH, 32'h00FF);
		p_en <= 16'hF0F0;
		p_oe <= 16'hF000;
		p_dat <= 16'hA5A5;
		settle();
		check({pin_oe, pin_o}, {16'hFFFF, 16'hA0FF});
		check({16'h0, p_din}, 32'h0000A000);
		rchk(gpio_pkg::OFF_LEVEL, 32'h0000A0FF);
		// Input-only sharing leaves a plain input pin.
		p_en <= 16'hFFFF;
		p_oe <= 16'h0000;
		ext_v <= 16'h3C3C;
		wr(gpio_pkg::OFF_DIR, 32'hFFFF);
		settle();
		check({pin_oe, p_din}, {16'h0, 16'h3C3C});
		rchk(gpio_pkg::OFF_LEVEL, 32'h3C3C);
		p_en <= 16'h0;
		// Weak pulls split across two registers, kept exclusive.
		seed = lfsr(seed);
		wr(gpio_pkg::OFF_PU_LO, {16'h0, seed[15:0]});
		wr(gpio_pkg::OFF_PU_HI, {25'h0, seed[22:16]});
		wr(gpio_pkg::OFF_PD_LO, {16'h0, ~seed[15:0]});
		wr(gpio_pkg::OFF_PD_HI, {25'h0, ~seed[22:16]});
		settle();
		check({9'h0, pu}, {9'h0, seed[22:0]});
		check({9'h0, pd}, {9'h0, ~seed[22:0]});
		// Change notice on the first and last inputs only.
		wr(gpio_pkg::OFF_CNEN_LO, 32'h1);
		wr(gpio_pkg::OFF_CNEN_HI, 32'h40);
		settle();
		cn <= 23'h20;
		repeat (6) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		for (int i = 0; i < 2; i++) begin
			cn <= cn ^ (23'h1 << (i * 22));
			repeat (5) @(posedge clk);
			check({31'h0, irq}, 32'h1);
			rchk(gpio_pkg::OFF_STATUS, 32'h1);
			wr(gpio_pkg::OFF_STATUS, 32'h1);
			settle();
			check({31'h0, irq}, 32'h0);
		end
		// Pulls go off before any pin turns into a digital output.
		wr(gpio_pkg::OFF_PU_LO, 32'h0);
		wr(gpio_pkg::OFF_PU_HI, 32'h0);
		wr(gpio_pkg::OFF_PD_LO, 32'h0);
		wr(gpio_pkg::OFF_PD_HI, 32'h0);
		settle();
		check({9'h0, pu | pd}, 32'h0);
		// Deep sleep freezes the pads until restore is cleared.
		wr(gpio_pkg::OFF_DIR, 32'h0);
		dsleep <= 1'b1;
		@(posedge clk);
		dsleep <= 1'b0;
		settle();
		check({31'h0, restore}, 32'h1);
		wr(gpio_pkg::OFF_LATCH, 32'hFF00);
		settle();
		check({16'h0, pin_o}, 32'h00FF);
		wr(gpio_pkg::OFF_STATUS, 32'h0);
		settle();
		check({15'h0, restore, pin_o}, 32'hFF00);
		// Unmapped place: write ignored, read zero, always OKAY.
		wr(8'h30, 32'hFFFFFFFF);
		rchk(8'h30, 32'h0);
		check({31'h0, hresp}, 32'h0);
		summarize();
	end
endmodule : shared_io_port_with_change_notice_tb
